// [include/rtf_params.svh]
// Constants of the read trigger front end: offsets, fields, resets, timing
`ifndef RTF_PARAMS_SVH
`define RTF_PARAMS_SVH

`define RTF_CLK_MHZ 200
`define RTF_TICK_US 32
`define RTF_FILT_W 16
`define RTF_FILT_RST 16'h0001
`define RTF_CHAR_RST 8'h20
`define RTF_CHAR_NUL 8'h00
`define RTF_CHAR_OPEN 8'h3C
`define RTF_CHAR_CLOSE 8'h3E

`define RTF_MODE_CONT 3'h0
`define RTF_MODE_CONT1 3'h1
`define RTF_MODE_LEVEL 3'h2
`define RTF_MODE_EDGE 3'h3
`define RTF_MODE_SERIAL 3'h4
`define RTF_MODE_SER_EDGE 3'h5
`define RTF_MODE_RST 3'h3
`define RTF_POL_RST 1'b1

`define RTF_OFS_CONFIG 8'h00
`define RTF_OFS_LEAD 8'h04
`define RTF_OFS_TRAIL 8'h08
`define RTF_OFS_CHAR 8'h0C
`define RTF_OFS_STATUS 8'h10

`define RTF_CFG_MODE_LSB 0
`define RTF_CFG_POL_BIT 8
`define RTF_ST_RAW_BIT 0
`define RTF_ST_FILT_BIT 1
`define RTF_ST_ACTIVE_BIT 2

`define RTF_RESP_OKAY 2'h0
`define RTF_RESP_SLVERR 2'h2

`endif

// [include/rtf_pkg.sv]
// Types and mode decoding of the read trigger front end
`include "rtf_params.svh"
package rtf_pkg;

  typedef enum logic [1:0] {SER_IDLE, SER_OPEN, SER_CHAR} rtf_ser_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rtf_rx_byte_t;

  typedef struct packed {
    logic [2:0] mode;
    logic pol;
    logic [`RTF_FILT_W-1:0] lead;
    logic [`RTF_FILT_W-1:0] trail;
    logic [7:0] tchar;
  } rtf_cfg_t;

  function automatic logic is_ext_mode(input logic [2:0] mode);
    return (mode == `RTF_MODE_LEVEL) || (mode == `RTF_MODE_EDGE) ||
           (mode == `RTF_MODE_SER_EDGE);
  endfunction : is_ext_mode

  function automatic logic is_serial_mode(input logic [2:0] mode);
    return (mode == `RTF_MODE_SERIAL) || (mode == `RTF_MODE_SER_EDGE);
  endfunction : is_serial_mode

endpackage : rtf_pkg

// [hw/rtf_filter.sv]
// Leading and trailing edge stability filter on the trigger input
`timescale 1ns/1ps
`include "rtf_params.svh"
module rtf_filter
  import rtf_pkg::*;
#(
  parameter int LEN_W = `RTF_FILT_W
)(
  input wire logic aclk,                 // Device clock
  input wire logic aresetn,              // Synchronous reset, active low
  input wire logic enable,               // External trigger mode selected
  input wire logic tick,                 // One pulse per filter tick
  input wire logic raw,                  // Synchronised, polarity corrected input
  input wire logic [LEN_W-1:0] lead_len, // Ticks needed to go active
  input wire logic [LEN_W-1:0] trail_len, // Ticks needed to go inactive
  output logic level                     // Filtered trigger state
);

  logic level_reg;
  logic level_next;
  logic [LEN_W-1:0] cnt_reg;
  logic [LEN_W-1:0] cnt_next;

  wire differs = raw != level_reg;
  wire [LEN_W-1:0] need = raw ? lead_len : trail_len;
  wire [LEN_W:0] cnt_inc = {1'b0, cnt_reg} + {{LEN_W{1'b0}}, 1'b1};
  // One tick beyond the setting: a change seen late in a period still waits N full ticks
  wire settled = (need == '0) || (tick && (cnt_reg >= need));

  // Any bounce back to the held state restarts the count
  always_comb
  begin
    level_next = level_reg;
    cnt_next = cnt_reg;
    if (!enable)
    begin
      level_next = 1'b0;
      cnt_next = '0;
    end
    else if (!differs)
      cnt_next = '0;
    else if (settled)
    begin
      level_next = raw;
      cnt_next = '0;
    end
    else if (tick)
      cnt_next = cnt_inc[LEN_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else
    begin
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign level = level_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_filter_hold: assert property (enable && differs && need != '0 && !tick |=>
    level_reg == $past(level_reg)) else $error("filtered level moved without a tick");
  a_zero_pass: assert property (enable && differs && need == '0 |=>
    level_reg == $past(raw)) else $error("zero setting did not pass input through");
  a_off_idle: assert property (!enable |=> !level_reg)
    else $error("filter active outside external modes");

endmodule : rtf_filter

// [hw/rtf_serial_trig.sv]
// Recogniser of the delimited serial trigger character
`timescale 1ns/1ps
`include "rtf_params.svh"
module rtf_serial_trig
  import rtf_pkg::*;
(
  input wire logic aclk,             // Device clock
  input wire logic aresetn,          // Synchronous reset, active low
  input wire rtf_rx_byte_t rx_byte,  // Received host byte, valid one cycle
  input wire logic [7:0] trig_char,  // Programmed trigger character
  output logic hit                   // One cycle pulse on a complete frame
);

  rtf_ser_state_t state_reg;
  rtf_ser_state_t state_next;
  logic hit_reg;

  wire is_open = rx_byte.data == `RTF_CHAR_OPEN;
  wire is_close = rx_byte.data == `RTF_CHAR_CLOSE;
  wire is_char = rx_byte.data == trig_char;
  wire frame_done = rx_byte.valid && state_reg == SER_CHAR && is_close;

  // A fresh opening bracket always restarts the frame
  always_comb
  begin
    state_next = state_reg;
    if (rx_byte.valid)
    begin
      case (state_reg)
        SER_IDLE: state_next = is_open ? SER_OPEN : SER_IDLE;
        SER_OPEN: state_next = is_char ? SER_CHAR : (is_open ? SER_OPEN : SER_IDLE);
        SER_CHAR: state_next = is_open ? SER_OPEN : SER_IDLE;
        default: state_next = SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= SER_IDLE;
      hit_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      hit_reg <= frame_done;
    end
  end

  assign hit = hit_reg;

endmodule : rtf_serial_trig

// [hw/rtf_top.sv]
// Read trigger front end: filtered external trigger, serial trigger, registers
//
// Operation
// - Input change accepted only after stable filter time
// - Edge mode starts after uninterrupted active filter time
// - Level mode activates after leading filter time
// - Level mode deactivates after trailing filter time
// - Leading filter 0..65535, resets to one
// - Trailing filter up to 65535, resets to one
// - Zero setting passes changes unfiltered
// - Filters work only in external modes
// - Polarity bit: 0 open, 1 closed
// - Delimited programmed character is a trigger
// - Character defaults to space, never NUL
// - Serial trigger only in serial modes
// - Serial start behaves like edge start
// - Level cycle lasts until input inactive
// - Edge cycle ignores input going inactive
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rtf_params.svh"
module rtf_top
  import rtf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int TICK_CYCLES = `RTF_TICK_US * `RTF_CLK_MHZ
)(
  input wire logic aclk,                   // Device clock, 200 MHz
  input wire logic aresetn,                // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr,    // Write address
  input wire logic [2:0] awprot,           // Write protection, unused
  input wire logic awvalid,                // Write address valid
  output logic awready,                    // Write address ready
  input wire logic [31:0] wdata,           // Write data
  input wire logic [3:0] wstrb,            // Write byte strobes
  input wire logic wvalid,                 // Write data valid
  output logic wready,                     // Write data ready
  output logic [1:0] bresp,                // Write response
  output logic bvalid,                     // Write response valid
  input wire logic bready,                 // Write response ready
  input wire logic [ADDR_W-1:0] araddr,    // Read address
  input wire logic [2:0] arprot,           // Read protection, unused
  input wire logic arvalid,                // Read address valid
  output logic arready,                    // Read address ready
  output logic [31:0] rdata,               // Read data
  output logic [1:0] rresp,                // Read response
  output logic rvalid,                     // Read data valid
  input wire logic rready,                 // Read data ready
  input wire logic trig_pin,               // External trigger pin, asynchronous
  input wire rtf_rx_byte_t rx_byte,        // Host serial byte stream
  input wire logic cycle_done,             // Good read or timeout, one cycle
  output logic read_start,                 // Read cycle start pulse
  output logic read_stop,                  // Read cycle end pulse
  output logic read_active                 // Read cycle in progress
);

  generate
    if (TICK_CYCLES < 3 || TICK_CYCLES > 65536 || ADDR_W < 8 || ADDR_W > 32)
    begin : g_bad_param
      $error("rtf_top: TICK_CYCLES must be 3..65536 and ADDR_W 8..32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction : merge_bytes

  function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
    logic [39:0] wide;
    logic [7:0] a;
    wide = 40'(addr);
    a = addr[7:0];
    return (wide[39:8] == 32'h00000000) &&
           (a == `RTF_OFS_CONFIG || a == `RTF_OFS_LEAD || a == `RTF_OFS_TRAIL ||
            a == `RTF_OFS_CHAR || a == `RTF_OFS_STATUS);
  endfunction : reg_known

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and tick generator

  logic trig_meta_reg;
  logic trig_sync_reg;
  logic [15:0] tick_cnt_reg;
  logic tick_reg;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
    end
    else
    begin
      trig_meta_reg <= trig_pin;
      trig_sync_reg <= trig_meta_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 16'h0000 : tick_cnt_reg + 16'h0001;
      tick_reg <= tick_cnt_reg == TICK_LAST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers over AXI4-Lite

  rtf_cfg_t cfg_reg;
  rtf_cfg_t cfg_next;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire aw_take = awvalid && awready_reg;
  wire w_take = wvalid && wready_reg;
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire aw_full_next = aw_take || (aw_full_reg && !do_write);
  wire w_full_next = w_take || (w_full_reg && !do_write);
  wire bvalid_next = do_write || (bvalid_reg && !bready);
  wire ar_take = arvalid && arready_reg;
  wire rvalid_next = ar_take || (rvalid_reg && !rready);

  wire [7:0] wofs = waddr_reg[7:0];
  wire [31:0] cfg_word = {23'h000000, cfg_reg.pol, 5'h00, cfg_reg.mode};
  wire [31:0] cfg_merged = merge_bytes(cfg_word, wdata_reg, wstrb_reg);
  wire [31:0] lead_merged = merge_bytes({16'h0000, cfg_reg.lead}, wdata_reg, wstrb_reg);
  wire [31:0] trail_merged = merge_bytes({16'h0000, cfg_reg.trail}, wdata_reg, wstrb_reg);
  wire [31:0] char_merged = merge_bytes({24'h000000, cfg_reg.tchar}, wdata_reg, wstrb_reg);
  wire [2:0] mode_new = cfg_merged[`RTF_CFG_MODE_LSB +: 3];
  wire mode_ok = mode_new <= `RTF_MODE_SER_EDGE;
  wire [7:0] char_new = char_merged[7:0];
  // Brackets are refused too: they would make the frame ambiguous
  wire char_ok = char_new != `RTF_CHAR_NUL && char_new != `RTF_CHAR_OPEN &&
                 char_new != `RTF_CHAR_CLOSE;

  // Illegal field values are dropped, the old setting stays
  always_comb
  begin
    cfg_next = cfg_reg;
    if (do_write && reg_known(waddr_reg))
    begin
      case (wofs)
        `RTF_OFS_CONFIG:
        begin
          if (mode_ok)
            cfg_next.mode = mode_new;
          cfg_next.pol = cfg_merged[`RTF_CFG_POL_BIT];
        end
        `RTF_OFS_LEAD: cfg_next.lead = lead_merged[15:0];
        `RTF_OFS_TRAIL: cfg_next.trail = trail_merged[15:0];
        `RTF_OFS_CHAR:
        begin
          if (char_ok)
            cfg_next.tchar = char_new;
        end
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg.mode <= `RTF_MODE_RST;
      cfg_reg.pol <= `RTF_POL_RST;
      cfg_reg.lead <= `RTF_FILT_RST;
      cfg_reg.trail <= `RTF_FILT_RST;
      cfg_reg.tchar <= `RTF_CHAR_RST;
    end
    else
      cfg_reg <= cfg_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RTF_RESP_OKAY;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg <= !w_full_next;
      bvalid_reg <= bvalid_next;
      if (aw_take)
        waddr_reg <= awaddr;
      if (w_take)
      begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_write)
        bresp_reg <= reg_known(waddr_reg) && wofs != `RTF_OFS_STATUS ?
                     `RTF_RESP_OKAY : `RTF_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger path

  logic filt_level;
  logic ser_hit;
  logic filt_prev_reg;
  logic read_start_reg;
  logic read_stop_reg;
  logic read_active_reg;

  wire raw_active = cfg_reg.pol ? trig_sync_reg : !trig_sync_reg;
  wire ext_on = is_ext_mode(cfg_reg.mode);
  wire ser_on = is_serial_mode(cfg_reg.mode);
  wire level_mode = cfg_reg.mode == `RTF_MODE_LEVEL;

  rtf_filter #(
    .LEN_W(`RTF_FILT_W)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ext_on),
    .tick(tick_reg),
    .raw(raw_active),
    .lead_len(cfg_reg.lead),
    .trail_len(cfg_reg.trail),
    .level(filt_level)
  );

  rtf_serial_trig u_serial (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_byte(rx_byte),
    .trig_char(cfg_reg.tchar),
    .hit(ser_hit)
  );

  wire filt_rise = filt_level && !filt_prev_reg;
  wire filt_fall = !filt_level && filt_prev_reg;
  wire ext_start = filt_rise && ext_on;
  wire ser_start = ser_hit && ser_on;
  wire start_ev = ext_start || ser_start;
  wire level_end = filt_fall && level_mode && read_active_reg;
  wire done_end = cycle_done && read_active_reg && !level_mode;
  // A new trigger in an edge-like cycle ends the old cycle as it starts the next
  wire retrig_end = start_ev && read_active_reg && !level_mode;
  wire active_next = start_ev || (read_active_reg && !level_end && !done_end);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_prev_reg <= 1'b0;
      read_start_reg <= 1'b0;
      read_stop_reg <= 1'b0;
      read_active_reg <= 1'b0;
    end
    else
    begin
      filt_prev_reg <= filt_level;
      read_start_reg <= start_ev;
      read_stop_reg <= level_end || done_end || retrig_end;
      read_active_reg <= active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  wire [7:0] rofs = araddr[7:0];
  wire [31:0] status_word = {29'h00000000, read_active_reg, filt_level, raw_active};
  wire [31:0] rd_mux =
    rofs == `RTF_OFS_CONFIG ? cfg_word :
    rofs == `RTF_OFS_LEAD ? {16'h0000, cfg_reg.lead} :
    rofs == `RTF_OFS_TRAIL ? {16'h0000, cfg_reg.trail} :
    rofs == `RTF_OFS_CHAR ? {24'h000000, cfg_reg.tchar} :
    status_word;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RTF_RESP_OKAY;
    end
    else
    begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= reg_known(araddr) ? rd_mux : 32'h00000000;
        rresp_reg <= reg_known(araddr) ? `RTF_RESP_OKAY : `RTF_RESP_SLVERR;
      end
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign read_start = read_start_reg;
  assign read_stop = read_stop_reg;
  assign read_active = read_active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ser_start;
    ser_hit && ser_on && !read_active_reg;
  endsequence

  sequence s_started;
    read_start_reg && read_active_reg;
  endsequence

  a_start_cause: assert property (read_start_reg |-> $past(start_ev))
    else $error("read start without a trigger");
  a_level_stop: assert property (level_end |=> read_stop_reg && !read_active_reg)
    else $error("level cycle not ended by inactive input");
  a_level_trail: assert property (level_mode && read_active_reg && !filt_level &&
    filt_prev_reg |=> !read_active_reg) else $error("level cycle outlived trailing filter");
  a_edge_keep: assert property (cfg_reg.mode == `RTF_MODE_EDGE && filt_fall &&
    read_active_reg && !cycle_done |=> read_active_reg)
    else $error("edge cycle ended by input release");
  a_serial_gate: assert property (ser_hit && !ser_on && !ext_start |=> !read_start_reg)
    else $error("serial trigger acted in a non-serial mode");
  a_serial_start: assert property (s_ser_start |=> s_started)
    else $error("serial trigger did not start a read cycle");
  a_char_legal: assert property (cfg_reg.tchar != `RTF_CHAR_NUL)
    else $error("trigger character became NUL");
  a_lead_rise: assert property (ext_start |-> $past(raw_active, 1))
    else $error("read started while input was not active");

endmodule : rtf_top

// [testbench/rtf_far_model.sv]
// Far side model: object sensor on the trigger pin and serial host
`timescale 1ns/1ps
`include "rtf_params.svh"
module rtf_far_model
  import rtf_pkg::*;
(
  input wire logic aclk,        // Device clock
  output logic trig_pin,        // Sensor contact level
  output rtf_rx_byte_t rx_byte  // Host byte stream
);
  logic [7:0] txq[$];

  initial
  begin
    trig_pin = 1'b0;
    rx_byte = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Idle data toggles every cycle so a stale byte is never taken for a new one
  always @(posedge aclk)
  begin
    if (txq.size() > 0)
      rx_byte <= '{valid: 1'b1, data: txq.pop_front()};
    else
      rx_byte <= '{valid: 1'b0, data: ~rx_byte.data};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Called right after a rising edge; the contact holds until told otherwise
  task automatic set_pin(input logic v);
    trig_pin <= v;
  endtask : set_pin

  task automatic frame(input logic [7:0] ch);
    txq.push_back(`RTF_CHAR_OPEN);
    txq.push_back(ch);
    txq.push_back(`RTF_CHAR_CLOSE);
    wait (txq.size() == 0);
    @(posedge aclk);
  endtask : frame
endmodule : rtf_far_model

// [testbench/tb_top.sv]
// Self-checking bench of the read trigger front end
`timescale 1ns/1ps
`include "rtf_params.svh"
module tb_top
  import rtf_pkg::*;
;
  localparam int TICK = 4;
  localparam logic [7:0] CFG = `RTF_OFS_CONFIG;
  localparam logic [7:0] LEAD = `RTF_OFS_LEAD;
  localparam logic [7:0] TRAIL = `RTF_OFS_TRAIL;
  localparam logic [7:0] CHR = `RTF_OFS_CHAR;
  localparam logic [1:0] OK = `RTF_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cycle_done = 1'b0;
  logic [2:0] prot = 3'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, read_start, read_stop, read_active;
  logic trig_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rtf_rx_byte_t rx_byte;
  logic [2:0] no_pin [3] = '{3'h0, 3'h1, 3'h4};
  int miscompares = 0;
  int checked = 0;
  int starts = 0;
  int stops = 0;
  int s0, p0;

  always #2.5 aclk = ~aclk;

  // Pulses are counted mid-cycle where they are settled
  always @(negedge aclk)
  begin
    starts += (read_start === 1'b1);
    stops += (read_stop === 1'b1);
  end

  rtf_top #(.TICK_CYCLES(TICK)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(prot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .trig_pin(trig_pin), .rx_byte(rx_byte), .cycle_done(cycle_done),
    .read_start(read_start), .read_stop(read_stop), .read_active(read_active)
  );

  rtf_far_model far_u (.aclk(aclk), .trig_pin(trig_pin), .rx_byte(rx_byte));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Handshakes are sampled mid-cycle, the value the next rising edge will see
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, ha, hw, got;
    logic [1:0] r;
    ad = 1'b0;
    wd = 1'b0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got)
    begin
      @(negedge aclk);
      ha = awready & ~ad;
      hw = wready & ~wd;
      got = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      ad = ad | ha;
      wd = wd | hw;
    end
    bready <= 1'b0;
    check("bresp", r, er);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, got;
    logic [31:0] d;
    logic [1:0] r;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(negedge aclk);
      ha = arready & arvalid;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check("rdata", d, ed);
    check("rresp", r, er);
    @(posedge aclk);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic mark();
    s0 = starts;
    p0 = stops;
  endtask : mark

  task automatic done_pulse();
    cycle_done <= 1'b1;
    @(posedge aclk);
    cycle_done <= 1'b0;
    cyc(3);
  endtask : done_pulse

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CFG, 32'h0000_0103, OK);
    rd(LEAD, 32'h0000_0001, OK);
    rd(TRAIL, 32'h0000_0001, OK);
    rd(CHR, 32'h0000_0020, OK);
    rd(8'h14, 32'h0000_0000, `RTF_RESP_SLVERR);
    // Edge mode, no leading filter
    wr(LEAD, 32'h0, OK);
    mark();
    far_u.set_pin(1'b1);
    cyc(8);
    check("start", starts - s0, 1);
    far_u.set_pin(1'b0);
    cyc(12);
    check("active", read_active, 1'b1);
    done_pulse();
    check("stop", stops - p0, 1);
    check("active", read_active, 1'b0);
    // Only the low byte lane is written; the upper lead byte stays zero
    wstrb <= 4'h1;
    wr(LEAD, 32'h0000_FF03, OK);
    wstrb <= 4'hF;
    rd(LEAD, 32'h0000_0003, OK);
    // A pulse shorter than the leading filter must not start a cycle
    mark();
    far_u.set_pin(1'b1);
    cyc(TICK);
    far_u.set_pin(1'b0);
    cyc(20);
    check("start", starts - s0, 0);
    far_u.set_pin(1'b1);
    cyc(6);
    check("start", starts - s0, 0);
    cyc(20);
    check("start", starts - s0, 1);
    done_pulse();
    far_u.set_pin(1'b0);
    cyc(20);
    // Level mode
    wr(LEAD, 32'h0, OK);
    wr(TRAIL, 32'h2, OK);
    wr(CFG, 32'h0000_0102, OK);
    mark();
    far_u.set_pin(1'b1);
    cyc(8);
    check("start", starts - s0, 1);
    done_pulse();
    check("active", read_active, 1'b1);
    rd(8'h10, 32'h0000_0007, OK);
    far_u.set_pin(1'b0);
    cyc(2);
    far_u.set_pin(1'b1);
    cyc(20);
    check("stop", stops - p0, 0);
    far_u.set_pin(1'b0);
    cyc(20);
    check("stop", stops - p0, 1);
    check("active", read_active, 1'b0);
    // Modes that leave the pin unused
    foreach (no_pin[i])
    begin
      wr(CFG, {23'h0, 1'b1, 5'h0, no_pin[i]}, OK);
      mark();
      far_u.set_pin(1'b1);
      cyc(12);
      far_u.set_pin(1'b0);
      cyc(12);
      check("start", starts - s0, 0);
    end
    // Active open: a low pin is the active state
    far_u.set_pin(1'b1);
    wr(CFG, 32'h0000_0003, OK);
    cyc(8);
    mark();
    far_u.set_pin(1'b0);
    cyc(8);
    check("start", starts - s0, 1);
    done_pulse();
    // Delimited serial trigger
    wr(CFG, 32'h0000_0104, OK);
    mark();
    far_u.frame(`RTF_CHAR_RST);
    cyc(4);
    check("start", starts - s0, 1);
    check("active", read_active, 1'b1);
    done_pulse();
    check("stop", stops - p0, 1);
    wr(CFG, 32'h0000_0103, OK);
    mark();
    far_u.frame(`RTF_CHAR_RST);
    cyc(4);
    check("start", starts - s0, 0);
    wr(CFG, 32'h0000_0105, OK);
    wr(CHR, 32'h0000_0041, OK);
    wr(CHR, 32'h0000_0000, OK);
    rd(CHR, 32'h0000_0041, OK);
    far_u.frame(`RTF_CHAR_RST);
    cyc(4);
    check("start", starts - s0, 0);
    far_u.frame(8'h41);
    cyc(4);
    check("start", starts - s0, 1);
    mark();
    far_u.frame(8'h41);
    cyc(4);
    check("restart", starts - s0, 1);
    check("stop", stops - p0, 1);
    check("active", read_active, 1'b1);
    done_pulse();
    print_verdict();
  end

  // Whole run takes under two thousand cycles
  initial
  begin
    cyc(20000);
    miscompares++;
    print_verdict();
  end
endmodule : tb_top
